/* File: rtl/smc_stepper_status.sv */
// Mode selection, lamp codes, fault output and setup-menu entry of a stepper drive
// Assumes APB master on pclk; pins and switches are asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none
`include "smc_regs.svh"
module smc_stepper_status
	import smc_pkg::*;
#(
	parameter int unsigned ENTRY_CYCLES = `SMC_ENTRY_CYCLES,
	parameter int unsigned IDLE_CYCLES  = `SMC_IDLE_CYCLES,
	parameter int unsigned BLINK_CYCLES = `SMC_BLINK_CYCLES,
	parameter int unsigned FAST_CYCLES  = `SMC_FAST_CYCLES,
	parameter int unsigned MAX_STEP_HZ  = 200000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        step_pulse,
	input  wire logic        rotation_sense,
	input  wire logic        run_request,
	input  wire logic        clockwise_request,
	input  wire logic        counter_rotation_request,
	input  wire logic        drive_enable_in,
	input  wire logic [12:0] analog_speed_in,
	input  wire logic [7:0]  config_switch_bank,
	input  wire logic        volt_trip_in,
	input  wire logic        curr_trip_in,
	output logic             step_advance,
	output logic             motor_dir,
	output logic [15:0]      motor_speed,
	output logic             drive_on,
	output logic             fault_out,
	output logic             lamp_green,
	output logic             lamp_blue,
	output logic             lamp_orange,
	output logic             lamp_red
);
	localparam int unsigned NSYNC = 16;
	// Two-flop synchronisers; first stage is read only by the second
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [12:0]      an_a;
	logic [12:0]      an_b;
	logic [NSYNC-1:0] raw_in;
	assign raw_in = {volt_trip_in, curr_trip_in, drive_enable_in, counter_rotation_request,
		clockwise_request, run_request, rotation_sense, step_pulse, config_switch_bank};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= '0;
			sync_b <= '0;
			an_a   <= '0;
			an_b   <= '0;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			an_a   <= analog_speed_in;
			an_b   <= an_a;
		end
	end
	logic [7:0] sw;
	logic       s_step, s_dir, s_run, s_cw, s_ccw, s_ena, s_curr, s_volt;
	assign sw     = sync_b[7:0];
	assign s_step = sync_b[8];
	assign s_dir  = sync_b[9];
	assign s_run  = sync_b[10];
	assign s_cw   = sync_b[11];
	assign s_ccw  = sync_b[12];
	assign s_ena  = sync_b[13];
	assign s_curr = sync_b[14];
	assign s_volt = sync_b[15];

	// Registers: ctrl (save strobe, preset speed), config (mode, bipolar)
	logic [31:0] ctrl, next_ctrl, config_r, next_config;
	logic [31:0] steps, next_steps;
	logic        step_q, save_evt;
	smc_mode_t   mode;
	logic        bipolar;
	assign mode    = smc_mode_t'(config_r[1:0]);
	assign bipolar = config_r[2];
	logic acc;
	assign acc = psel && penable;
	assign pready  = 1'b1;
	assign pslverr = acc && !(paddr == `SMC_OFF_CTRL || paddr == `SMC_OFF_CONFIG ||
		paddr == `SMC_OFF_STATUS || paddr == `SMC_OFF_STEPS || paddr == `SMC_OFF_SPEED ||
		paddr == `SMC_OFF_FAULT);

	// Drive state and lamps
	smc_drive_t drv, next_drv;
	smc_setup_t su, next_su;
	logic       rise;
	logic [31:0] freq_cnt, next_freq_cnt;
	logic [15:0] per_win, next_per_win;
	localparam int unsigned WIN = `SMC_CLK_HZ / 1000;
	localparam int unsigned MAX_PER_WIN = MAX_STEP_HZ / 1000;
	assign rise = s_step && !step_q;

	always_comb begin
		next_ctrl   = ctrl & 32'hFFFF_FFFE;
		next_config = config_r;
		if (acc && pwrite && paddr == `SMC_OFF_CTRL)
			next_ctrl = pwdata;
		if (acc && pwrite && paddr == `SMC_OFF_CONFIG)
			next_config = pwdata;
		next_steps = steps;
		if (rise && drv == SMC_ST_RUN && mode == SMC_MODE_STEP_DIR && su == SMC_SU_IDLE)
			next_steps = s_dir ? steps - 32'd1 : steps + 32'd1;
	end
	assign save_evt = ctrl[0];

	always_comb begin
		next_drv      = drv;
		next_freq_cnt = (freq_cnt >= WIN - 1) ? 32'd0 : freq_cnt + 32'd1;
		next_per_win  = (freq_cnt >= WIN - 1) ? 16'd0 : per_win + {15'd0, rise};
		unique case (drv)
			SMC_ST_RUN: begin
				if (!s_ena)
					next_drv = SMC_ST_DISABLED;
				else if (s_volt)
					next_drv = SMC_ST_VOLT;
				else if (s_curr)
					next_drv = SMC_ST_CURR;
				else if (per_win > 16'(MAX_PER_WIN))
					next_drv = SMC_ST_FREQ;
			end
			SMC_ST_DISABLED: if (s_ena) next_drv = SMC_ST_RUN;
			SMC_ST_VOLT, SMC_ST_CURR, SMC_ST_FREQ: begin
				if (!s_ena)
					next_drv = SMC_ST_DISABLED;
			end
			default: next_drv = SMC_ST_DISABLED;
		endcase
	end

	// Setup entry: four on-presses of switch four within the window, then off
	logic [2:0]  press, next_press;
	logic [31:0] win_cnt, next_win_cnt, idle_cnt, next_idle_cnt;
	logic [7:0]  sw_q;
	logic        sw4_rise, sw_any, sw_chg;
	assign sw4_rise = sw[3] && !sw_q[3];
	assign sw_any   = |sw;
	assign sw_chg   = sw != sw_q;
	always_comb begin
		next_su       = su;
		next_press    = press;
		next_win_cnt  = win_cnt;
		next_idle_cnt = sw_chg ? 32'd0 : idle_cnt + 32'd1;
		unique case (su)
			SMC_SU_IDLE: begin
				next_idle_cnt = 32'd0;
				if (press != 3'd0)
					next_win_cnt = win_cnt + 32'd1;
				if (press != 3'd0 && win_cnt >= ENTRY_CYCLES) begin
					next_press   = 3'd0;
					next_win_cnt = 32'd0;
				end else if (sw4_rise) begin
					next_press = press + 3'd1;
					if (press == 3'd0)
						next_win_cnt = 32'd0;
				end else if (press == 3'd4 && !sw[3]) begin
					next_su      = sw_any ? SMC_SU_CLEAR : SMC_SU_ITEM;
					next_press   = 3'd0;
					next_win_cnt = 32'd0;
				end
			end
			SMC_SU_CLEAR: if (!sw_any) next_su = SMC_SU_ITEM;
			SMC_SU_ITEM: if (sw_any) next_su = SMC_SU_VALUE;
			SMC_SU_VALUE: if (save_evt) next_su = SMC_SU_IDLE;
		endcase
		if (su != SMC_SU_IDLE && idle_cnt >= IDLE_CYCLES - 1)
			next_su = SMC_SU_IDLE;
	end

	// Speed: analogue input in millivolts, unipolar 0..5000, bipolar centre 2500
	logic [15:0] lim, target, next_speed, ramp_step;
	logic [12:0] mag;
	logic        an_neg, an_zero, next_dir;
	logic [31:0] ramp_ms;
	logic [31:0] tick_cnt, next_tick_cnt;
	always_comb begin
		an_neg = bipolar && an_b < 13'd2500;
		if (!bipolar)
			mag = an_b;
		else if (an_neg)
			mag = 13'd2500 - an_b;
		else
			mag = an_b - 13'd2500;
		an_zero = mag <= 13'(`SMC_DEAD_MV);
		unique case ({sw[7], sw[6]})
			2'b00:   lim = `SMC_LIM_HALF;
			2'b01:   lim = `SMC_LIM_6;
			2'b10:   lim = `SMC_LIM_25;
			default: lim = `SMC_LIM_50;
		endcase
		unique case ({sw[5], sw[4]})
			2'b00:   ramp_ms = `SMC_RAMP_0_1_MS;
			2'b01:   ramp_ms = `SMC_RAMP_1_MS;
			2'b10:   ramp_ms = `SMC_RAMP_2_MS;
			default: ramp_ms = `SMC_RAMP_4_MS;
		endcase
		target   = 16'd0;
		next_dir = motor_dir;
		unique case (mode)
			SMC_MODE_STEP_DIR: next_dir = s_dir;
			SMC_MODE_RUN_DIR: begin
				target   = s_run ? ctrl[31:16] : 16'd0;
				next_dir = s_dir;
			end
			SMC_MODE_CW_CCW: begin
				target = (s_cw ^ s_ccw) ? ctrl[31:16] : 16'd0;
				if (s_cw ^ s_ccw)
					next_dir = s_ccw;
			end
			SMC_MODE_ANALOG: begin
				if (!an_zero) begin
					if (bipolar)
						target = 16'((32'(mag) * 32'd2 * 32'(`SMC_MAX_SPEED)) / 32'd5000);
					else
						target = 16'(({3'd0, mag} * 32'(lim)) / 32'd5000);
				end
				if (bipolar && !an_zero)
					next_dir = an_neg;
				else if (!bipolar && an_zero)
					next_dir = s_dir;
			end
		endcase
		if (drv != SMC_ST_RUN || su != SMC_SU_IDLE)
			target = 16'd0;
		ramp_step     = 16'd1;
		next_tick_cnt = tick_cnt + 32'd1;
		next_speed    = motor_speed;
		if (drv == SMC_ST_VOLT || drv == SMC_ST_CURR || drv == SMC_ST_FREQ ||
			(mode == SMC_MODE_ANALOG && bipolar))
			next_speed = target;
		else if (tick_cnt >= (ramp_ms * `SMC_MS_CYCLES) / `SMC_MAX_SPEED) begin
			next_tick_cnt = 32'd0;
			if (motor_speed < target)
				next_speed = motor_speed + ramp_step;
			else if (motor_speed > target)
				next_speed = motor_speed - ramp_step;
		end
	end

	// Lamp blink timing
	logic [31:0] blk_cnt, next_blk_cnt;
	logic [3:0]  phase, next_phase;
	logic [31:0] fast_cnt, next_fast_cnt;
	logic        fast_q, next_fast_q, save_lamp, next_save_lamp;
	logic [3:0]  npulse;
	logic        red_code;
	always_comb begin
		next_blk_cnt  = blk_cnt + 32'd1;
		next_phase    = phase;
		if (blk_cnt >= BLINK_CYCLES - 1) begin
			next_blk_cnt = 32'd0;
			next_phase   = phase + 4'd1;
		end
		next_fast_cnt = fast_cnt + 32'd1;
		next_fast_q   = fast_q;
		if (fast_cnt >= FAST_CYCLES - 1) begin
			next_fast_cnt = 32'd0;
			next_fast_q   = !fast_q;
		end
		next_save_lamp = save_evt || (save_lamp && !(blk_cnt >= BLINK_CYCLES - 1));
		unique case (drv)
			SMC_ST_DISABLED: npulse = 4'd1;
			SMC_ST_VOLT:     npulse = 4'd2;
			SMC_ST_CURR:     npulse = 4'd3;
			SMC_ST_FREQ:     npulse = 4'd5;
			default:         npulse = 4'd0;
		endcase
		red_code = !phase[0] && (phase[3:1] < npulse[2:0]) && npulse != 4'd0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl        <= `SMC_CTRL_RST;
			config_r    <= `SMC_CONFIG_RST;
			steps       <= '0;
			step_q      <= 1'b0;
			sw_q        <= '0;
			drv         <= SMC_ST_DISABLED;
			su          <= SMC_SU_IDLE;
			press       <= '0;
			win_cnt     <= '0;
			idle_cnt    <= '0;
			freq_cnt    <= '0;
			per_win     <= '0;
			motor_speed <= '0;
			motor_dir   <= 1'b0;
			tick_cnt    <= '0;
			blk_cnt     <= '0;
			phase       <= '0;
			fast_cnt    <= '0;
			fast_q      <= 1'b0;
			save_lamp   <= 1'b0;
		end else begin
			ctrl        <= next_ctrl;
			config_r    <= next_config;
			steps       <= next_steps;
			step_q      <= s_step;
			sw_q        <= sw;
			drv         <= next_drv;
			su          <= next_su;
			press       <= next_press;
			win_cnt     <= next_win_cnt;
			idle_cnt    <= next_idle_cnt;
			freq_cnt    <= next_freq_cnt;
			per_win     <= next_per_win;
			motor_speed <= next_speed;
			motor_dir   <= next_dir;
			tick_cnt    <= next_tick_cnt;
			blk_cnt     <= next_blk_cnt;
			phase       <= next_phase;
			fast_cnt    <= next_fast_cnt;
			fast_q      <= next_fast_q;
			save_lamp   <= next_save_lamp;
		end
	end

	// Outputs registered; step pulse only forwarded in step mode while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_advance <= 1'b0;
			drive_on     <= 1'b0;
			fault_out    <= 1'b0;
			lamp_green   <= 1'b0;
			lamp_blue    <= 1'b0;
			lamp_orange  <= 1'b0;
			lamp_red     <= 1'b0;
			prdata       <= '0;
		end else begin
			step_advance <= rise && drv == SMC_ST_RUN && mode == SMC_MODE_STEP_DIR &&
				su == SMC_SU_IDLE;
			drive_on     <= drv == SMC_ST_RUN || (drv == SMC_ST_DISABLED && motor_speed != 16'd0);
			fault_out    <= drv == SMC_ST_VOLT || drv == SMC_ST_CURR;
			if (su == SMC_SU_IDLE) begin
				lamp_green  <= mode == SMC_MODE_STEP_DIR;
				lamp_blue   <= mode == SMC_MODE_RUN_DIR || mode == SMC_MODE_CW_CCW;
				lamp_orange <= mode == SMC_MODE_ANALOG;
				lamp_red    <= red_code || save_lamp;
			end else begin
				lamp_blue   <= 1'b0;
				lamp_orange <= 1'b0;
				lamp_red    <= (su == SMC_SU_CLEAR && fast_q) || save_lamp;
				if (su == SMC_SU_ITEM)
					lamp_green <= phase[0];
				else if (su == SMC_SU_VALUE)
					lamp_green <= phase[2:0] == 3'd0;
				else
					lamp_green <= 1'b0;
			end
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`SMC_OFF_CTRL:   prdata <= ctrl;
					`SMC_OFF_CONFIG: prdata <= config_r;
					`SMC_OFF_STATUS: prdata <= {25'd0, drv, su, motor_dir};
					`SMC_OFF_STEPS:  prdata <= steps;
					`SMC_OFF_SPEED:  prdata <= {16'd0, motor_speed};
					`SMC_OFF_FAULT:  prdata <= {31'd0, fault_out};
					default:         prdata <= '0;
				endcase
			end
		end
	end
endmodule // smc_stepper_status
`default_nettype wire

/* File: include/smc_regs.svh */
// Register offsets, reset values, speed limits, ramp times and timing counts
// Assumes pclk at 50 MHz and a 32-bit APB slave
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_CLK_HZ           50000000
`define SMC_OFF_CTRL         12'h000
`define SMC_OFF_CONFIG       12'h004
`define SMC_OFF_STATUS       12'h008
`define SMC_OFF_STEPS        12'h00C
`define SMC_OFF_SPEED        12'h010
`define SMC_OFF_FAULT        12'h014
`define SMC_CTRL_RST         32'h0000_0000
`define SMC_CONFIG_RST       32'h0000_0032
`define SMC_MAX_SPEED        16'd5000
`define SMC_LIM_HALF         16'd50
`define SMC_LIM_6            16'd600
`define SMC_LIM_25           16'd2500
`define SMC_LIM_50           16'd5000
`define SMC_DEAD_MV          12'd100
`define SMC_RAMP_0_1_MS      32'd100
`define SMC_RAMP_1_MS        32'd1000
`define SMC_RAMP_2_MS        32'd2000
`define SMC_RAMP_4_MS        32'd4000
`define SMC_ENTRY_MS         32'd3000
`define SMC_IDLE_S           32'd30
`define SMC_MS_CYCLES        (`SMC_CLK_HZ / 1000)
`define SMC_ENTRY_CYCLES     (`SMC_ENTRY_MS * `SMC_MS_CYCLES)
`define SMC_IDLE_CYCLES      (`SMC_IDLE_S * `SMC_CLK_HZ)
`define SMC_BLINK_CYCLES     (`SMC_CLK_HZ / 8)
`define SMC_FAST_CYCLES      (`SMC_CLK_HZ / 32)
`endif

/* File: include/smc_pkg.sv */
// Types shared by the stepper mode/status/setup block
package smc_pkg;
	typedef enum logic [1:0] {
		SMC_MODE_STEP_DIR = 2'b00,
		SMC_MODE_RUN_DIR  = 2'b01,
		SMC_MODE_CW_CCW   = 2'b10,
		SMC_MODE_ANALOG   = 2'b11
	} smc_mode_t;
	typedef enum logic [2:0] {
		SMC_ST_RUN      = 3'b000,
		SMC_ST_DISABLED = 3'b001,
		SMC_ST_VOLT     = 3'b010,
		SMC_ST_CURR     = 3'b011,
		SMC_ST_FREQ     = 3'b100
	} smc_drive_t;
	typedef enum logic [1:0] {
		SMC_SU_IDLE  = 2'b00,
		SMC_SU_CLEAR = 2'b01,
		SMC_SU_ITEM  = 2'b10,
		SMC_SU_VALUE = 2'b11
	} smc_setup_t;
endpackage

/* File: dv/smc_stepper_status_sva.sv */
// Port-level assertions for the stepper mode, lamp and fault block
// Assumes it is bound onto smc_stepper_status with one clock, pclk
`timescale 1ns/10ps
`default_nettype none
module smc_checker #(
	parameter int unsigned BLINK_CYCLES = 16
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	input wire logic        step_pulse,
	input wire logic        drive_enable_in,
	input wire logic        volt_trip_in,
	input wire logic        step_advance,
	input wire logic        drive_on,
	input wire logic        fault_out,
	input wire logic        lamp_green,
	input wire logic        lamp_blue,
	input wire logic        lamp_orange,
	input wire logic        lamp_red
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pause length is the designer's; allow a generous gap between red pulses
	localparam int unsigned RED_GAP = 32 * BLINK_CYCLES;
	logic [15:0] red_gap;
	logic [15:0] next_red_gap;
	always_comb begin
		next_red_gap = (fault_out && !lamp_red) ? red_gap + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			red_gap <= 16'h0000;
		else
			red_gap <= next_red_gap;
	end
	sequence s_edge_in;
		$rose(step_pulse) && drive_on && lamp_green ##3 drive_on;
	endsequence
	sequence s_adv_out;
		##[0:2] step_advance;
	endsequence
	property p_step; s_edge_in |-> s_adv_out; endproperty
	property p_adv_once; step_advance |=> !step_advance; endproperty
	property p_adv_mode; step_advance && drive_on |-> lamp_green; endproperty
	property p_lamps; $onehot0({lamp_green, lamp_blue, lamp_orange}); endproperty
	property p_fault_off; fault_out |-> !drive_on; endproperty
	property p_volt; $rose(volt_trip_in) && drive_on |-> ##[1:8] fault_out; endproperty
	property p_hold;
		$fell(fault_out) |-> !$past(drive_enable_in, 2) || !$past(drive_enable_in, 3) || !$past(drive_enable_in, 4);
	endproperty
	property p_red; red_gap < RED_GAP; endproperty
	property p_slverr; psel && penable && paddr > 12'h014 |-> pslverr; endproperty
	a_step: assert property (p_step) else $error("no step advance after step edge");
	a_adv_once: assert property (p_adv_once) else $error("step advance wider than one cycle");
	a_adv_mode: assert property (p_adv_mode) else $error("step advance outside green mode");
	a_lamps: assert property (p_lamps) else $error("more than one mode lamp lit");
	a_fault_off: assert property (p_fault_off) else $error("drive on during fault");
	a_volt: assert property (p_volt) else $error("voltage trip not flagged");
	a_hold: assert property (p_hold) else $error("fault cleared without disable");
	a_red: assert property (p_red) else $error("red lamp silent during fault");
	a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
endmodule // smc_checker
bind smc_stepper_status smc_checker #(.BLINK_CYCLES(BLINK_CYCLES)) smc_checker_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr), .step_pulse(step_pulse),
	.drive_enable_in(drive_enable_in), .volt_trip_in(volt_trip_in), .step_advance(step_advance),
	.drive_on(drive_on), .fault_out(fault_out), .lamp_green(lamp_green), .lamp_blue(lamp_blue),
	.lamp_orange(lamp_orange), .lamp_red(lamp_red));
`default_nettype wire

/* File: dv/smc_step_host.sv */
// Machine controller model issuing step pulse trains
// Assumes pclk shared with the block; six cycles per pulse clears the input synchroniser
`timescale 1ns/10ps
`default_nettype none
module smc_step_host (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [7:0] pulses,
	output logic            step_pulse,
	output logic            busy
);
	logic [7:0] left;
	logic [7:0] next_left;
	logic [2:0] ph;
	logic [2:0] next_ph;
	always_comb begin
		next_left = left;
		next_ph = ph;
		if (go && left == 8'h00) begin
			next_left = pulses;
			next_ph = 3'h0;
		end else if (left != 8'h00) begin
			next_ph = (ph == 3'h5) ? 3'h0 : ph + 3'h1;
			next_left = (ph == 3'h5) ? left - 8'h01 : left;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 8'h00;
			ph <= 3'h0;
		end else begin
			left <= next_left;
			ph <= next_ph;
		end
	end
	// Line rests low between trains, so no pulses reach a setup sequence
	assign step_pulse = (left != 8'h00) && (ph < 3'h3);
	assign busy = left != 8'h00;
endmodule // smc_step_host
`default_nettype wire

/* File: dv/smc_stepper_status_tb.sv */
// Self-checking bench for the stepper mode, lamp, fault and setup block
// Assumes short count parameters; the step host model drives step_pulse
`timescale 1ns/10ps
`default_nettype none
`include "smc_regs.svh"
module smc_stepper_status_tb
	import smc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rotation_sense, run_request;
	logic        clockwise_request, counter_rotation_request, drive_enable_in, volt_trip_in, curr_trip_in;
	logic        step_pulse, step_advance, motor_dir, drive_on, fault_out, go, busy;
	logic        lamp_green, lamp_blue, lamp_orange, lamp_red, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, s0;
	logic [12:0] analog_speed_in;
	logic [7:0]  config_switch_bank, pulses;
	logic [15:0] motor_speed;
	int          n_mismatch, num_checks, n_adv, a0, n, i;
	smc_stepper_status #(.ENTRY_CYCLES(200), .IDLE_CYCLES(2000), .BLINK_CYCLES(16), .FAST_CYCLES(4),
		.MAX_STEP_HZ(10000)) smc_stepper_status_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .step_pulse(step_pulse), .rotation_sense(rotation_sense), .run_request(run_request),
		.clockwise_request(clockwise_request), .counter_rotation_request(counter_rotation_request),
		.drive_enable_in(drive_enable_in), .analog_speed_in(analog_speed_in),
		.config_switch_bank(config_switch_bank), .volt_trip_in(volt_trip_in), .curr_trip_in(curr_trip_in),
		.step_advance(step_advance), .motor_dir(motor_dir), .motor_speed(motor_speed), .drive_on(drive_on),
		.fault_out(fault_out), .lamp_green(lamp_green), .lamp_blue(lamp_blue), .lamp_orange(lamp_orange),
		.lamp_red(lamp_red));
	smc_step_host smc_step_host_i (.pclk(pclk), .presetn(presetn), .go(go), .pulses(pulses),
		.step_pulse(step_pulse), .busy(busy));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) if (step_advance === 1'b1) n_adv++;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits on pready without assuming a latency
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task send(input logic [7:0] k);
		pulses <= k;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (2) @(posedge pclk);
		for (n = 0; n < 5000 && busy; n++) @(posedge pclk);
		repeat (10) @(posedge pclk);
	endtask
	task t_reset;
		chk("fault", fault_out, 0);
		for (n = 0; n < 500 && lamp_red !== 1'b1; n++) @(posedge pclk);
		chk("red disabled", lamp_red, 1);
		apb(0, `SMC_OFF_CONFIG, 0);
		chk("config rst", r, `SMC_CONFIG_RST);
		apb(0, 12'h020, 0);
		chk("unmapped err", e, 1);
		chk("unmapped data", r, 0);
		$display("done t_reset");
	endtask
	task t_step;
		apb(1, `SMC_OFF_CONFIG, 32'h0000_0000);
		drive_enable_in <= 1'b1;
		for (n = 0; n < 50 && drive_on !== 1'b1; n++) @(posedge pclk);
		chk("green", {lamp_green, lamp_blue, lamp_orange}, 4);
		a0 = n_adv;
		apb(0, `SMC_OFF_STEPS, 0);
		s0 = r;
		send(8'h05);
		chk("advances", n_adv - a0, 5);
		apb(0, `SMC_OFF_STEPS, 0);
		chk("step count", r - s0, 5);
		rotation_sense <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("dir level", motor_dir, 1);
		apb(1, `SMC_OFF_CTRL, 32'h0000_0001);
		for (n = 0; n < 40 && lamp_red !== 1'b1; n++) @(posedge pclk);
		chk("save pulse", lamp_red, 1);
		$display("done t_step");
	endtask
	task t_run;
		apb(1, `SMC_OFF_CTRL, 32'h03E8_0000);
		apb(1, `SMC_OFF_CONFIG, 32'h0000_0001);
		run_request <= 1'b1;
		for (n = 0; n < 5000 && motor_speed === 16'h0000; n++) @(posedge pclk);
		chk("blue", {lamp_green, lamp_blue, lamp_orange}, 2);
		chk("run speed", motor_speed != 16'h0000, 1);
		run_request <= 1'b0;
		apb(1, `SMC_OFF_CONFIG, 32'h0000_0002);
		counter_rotation_request <= 1'b1;
		for (n = 0; n < 5000 && motor_dir !== 1'b1; n++) @(posedge pclk);
		chk("left", motor_dir, 1);
		counter_rotation_request <= 1'b0;
		clockwise_request <= 1'b1;
		for (n = 0; n < 5000 && motor_dir !== 1'b0; n++) @(posedge pclk);
		chk("right", motor_dir, 0);
		clockwise_request <= 1'b0;
		$display("done t_run");
	endtask
	task t_analog;
		config_switch_bank <= 8'hC0;
		apb(1, `SMC_OFF_CONFIG, 32'h0000_0007);
		analog_speed_in <= 13'h0EA6;
		for (n = 0; n < 50 && motor_speed !== 16'h09C4; n++) @(posedge pclk);
		chk("orange", {lamp_green, lamp_blue, lamp_orange}, 1);
		chk("bip speed", motor_speed, 16'h09C4);
		chk("bip fwd", motor_dir, 0);
		analog_speed_in <= 13'h04E2;
		for (n = 0; n < 50 && motor_dir !== 1'b1; n++) @(posedge pclk);
		chk("bip rev", motor_dir, 1);
		analog_speed_in <= 13'h09F6;
		for (n = 0; n < 50 && motor_speed !== 16'h0000; n++) @(posedge pclk);
		chk("dead zone", motor_speed, 0);
		apb(1, `SMC_OFF_CONFIG, 32'h0000_0003);
		analog_speed_in <= 13'h0FA0;
		rotation_sense <= 1'b0;
		for (n = 0; n < 1200 && motor_speed === 16'h0000; n++) @(posedge pclk);
		chk("uni ramp", motor_speed, 1);
		chk("uni dir held", motor_dir, 1);
		analog_speed_in <= 13'h0000;
		repeat (10) @(posedge pclk);
		chk("uni dir zero", motor_dir, 0);
		config_switch_bank <= 8'h00;
		$display("done t_analog");
	endtask
	task t_trip;
		for (i = 0; i < 2; i++) begin
			drive_enable_in <= 1'b1;
			repeat (10) @(posedge pclk);
			if (i == 0)
				volt_trip_in <= 1'b1;
			else
				curr_trip_in <= 1'b1;
			repeat (5) @(posedge pclk);
			volt_trip_in <= 1'b0;
			curr_trip_in <= 1'b0;
			repeat (40) @(posedge pclk);
			chk("fault held", fault_out, 1);
			apb(0, `SMC_OFF_STATUS, 0);
			chk("trip state", r[5:3], i == 0 ? SMC_ST_VOLT : SMC_ST_CURR);
			drive_enable_in <= 1'b0;
			repeat (10) @(posedge pclk);
			chk("fault clear", fault_out, 0);
		end
		$display("done t_trip");
	endtask
	task t_setup;
		drive_enable_in <= 1'b1;
		// No step pulses are sent during programming
		for (i = 0; i < 4; i++) begin
			config_switch_bank <= 8'h08;
			repeat (5) @(posedge pclk);
			// Switch one goes on as switch four goes off, so entry goes to the clear state until all are off
			config_switch_bank <= (i == 3) ? 8'h01 : 8'h00;
			repeat (5) @(posedge pclk);
		end
		config_switch_bank <= 8'h01;
		for (n = 0; n < 50 && lamp_red !== 1'b1; n++) @(posedge pclk);
		chk("red fast", lamp_red, 1);
		apb(0, `SMC_OFF_STATUS, 0);
		chk("clear wait", r[2:1], SMC_SU_CLEAR);
		config_switch_bank <= 8'h00;
		for (n = 0; n < 100 && lamp_green !== 1'b1; n++) @(posedge pclk);
		for (n = 0; n < 100 && lamp_green !== 1'b0; n++) @(posedge pclk);
		chk("green flash", lamp_green, 0);
		apb(0, `SMC_OFF_STATUS, 0);
		chk("item wait", r[2:1], SMC_SU_ITEM);
		repeat (2100) @(posedge pclk);
		apb(0, `SMC_OFF_STATUS, 0);
		chk("idle exit", r[2:1], SMC_SU_IDLE);
		$display("done t_setup");
	endtask
	task t_freq;
		apb(1, `SMC_OFF_CONFIG, 32'h0000_0000);
		send(8'h1E);
		for (n = 0; n < 60000 && drive_on !== 1'b0; n++) @(posedge pclk);
		apb(0, `SMC_OFF_STATUS, 0);
		chk("freq trip", r[5:3], SMC_ST_FREQ);
		$display("done t_freq");
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, rotation_sense, run_request, go} = 7'h00;
		{clockwise_request, counter_rotation_request, drive_enable_in, volt_trip_in, curr_trip_in} = 5'h00;
		{paddr, pwdata, pulses, config_switch_bank, analog_speed_in} = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_step;
		t_run;
		t_analog;
		t_trip;
		t_setup;
		t_freq;
		results;
	end
	initial begin
		#(20 * 20000);
		n_mismatch++;
		results;
	end
endmodule // smc_stepper_status_tb
`default_nettype wire
